/* File: common/nab_pkg.sv */
// constants, field layout and operation codes of the nibble alu
package nab_pkg;
   // operations presented by the instruction sequencer
   typedef enum logic [2:0] {
      NAB_OP_SUM,
      NAB_OP_SUM_CARRY,
      NAB_OP_DIFF,
      NAB_OP_DIFF_BORROW,
      NAB_OP_OR,
      NAB_OP_AND,
      NAB_OP_XOR
   } nab_op_t;

   // register byte offsets on the axi4-lite port
   localparam logic [7:0] NAB_OFF_STATUS = 8'h00;
   localparam logic [7:0] NAB_OFF_MODE = 8'h04;
   localparam logic [7:0] NAB_OFF_INDEX = 8'h08;
   localparam logic [7:0] NAB_OFF_RESULT = 8'h0c;

   // program status word field positions
   localparam int NAB_SW_CARRY = 0;
   localparam int NAB_SW_NULL = 1;
   localparam int NAB_SW_COMPARE = 2;
   localparam int NAB_SW_INDEX_EN = 3;
   // mode register field position
   localparam int NAB_MODE_DECIMAL = 0;

   // reset values
   localparam logic [3:0] NAB_RST_STATUS = 4'h0;
   localparam logic NAB_RST_DECIMAL = 1'b0;
   localparam logic [6:0] NAB_RST_INDEX = 7'h00;
   localparam logic [4:0] NAB_RST_RESULT = 5'h00;

   // data memory address at which the status word is mapped
   localparam logic [6:0] NAB_STATUS_ADDR = 7'h7f;

   // decimal correction limits on the 5-bit binary result
   localparam logic [4:0] NAB_DEC_TEN = 5'h0a;
   localparam logic [4:0] NAB_DEC_TWENTY = 5'h14;
   localparam logic [3:0] NAB_DEC_NEG_LOW = 4'h6;
   localparam logic [1:0] NAB_DEC_BAD_HI = 2'h3;
   localparam logic [1:0] NAB_DEC_BAD_FLIP = 2'h2;

   // axi responses
   localparam logic [1:0] NAB_RESP_OKAY = 2'h0;
   localparam logic [1:0] NAB_RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/nab_alu.sv */
// 4-bit binary/decimal alu with status word and axi4-lite control registers
`timescale 1ns/1ps
// Overview of operation
// - four arithmetic ops, two operand pairings
// - decimal flag picks base, compare gates store
// - binary: store result, carry on overflow/underflow
// - compare clear: null flag equals zero result
// - compare set: arithmetic result never written back
// - compare set: zero keeps null, nonzero clears
// - compare set: carry still follows operation
// - decimal: carry above nine or below zero
// - decimal, compare clear: null on zero digit
// - decimal: binary result then decimal correction
// - out of range decimal: carry, digit >=1010B
// - decimal plus compare: both behaviours together
// - chained compare via preset flags and borrow
// - status word destination overwrites its flags
// - compare set: status operand flags stay valid
// - bitwise or, and, xor on nibbles
// - bitwise ops ignore modes, keep flags
// - index register modifies memory operand address
// - result goes to first operand location
module nab_alu #(
   parameter int AXI_AW = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   // sequencer side
   input wire logic opValid,
   input wire nab_pkg::nab_op_t opCode,
   input wire logic opImmForm,
   input wire logic [6:0] firstAddr,
   input wire logic [3:0] firstData,
   input wire logic [3:0] secondData,
   output logic wrValid,
   output logic wrToRegister,
   output logic [6:0] wrAddr,
   output logic [3:0] wrData,
   output logic carryFlag,
   output logic resultNullFlag,
   output logic compareModeFlag,
   output logic decimalModeFlag,
   output logic indexEnableFlag,
   // axi4-lite slave
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import nab_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // decimal correction of the 5-bit binary result into {carry, digit}
   function automatic logic [4:0] decCorrect(input logic [4:0] raw, input logic sub);
      logic [4:0] bad;
      bad = {1'b1, NAB_DEC_BAD_HI, raw[1:0] ^ NAB_DEC_BAD_FLIP};
      if (!sub) begin
         if (raw < NAB_DEC_TEN) begin
            decCorrect = raw;
         end else if (raw < NAB_DEC_TWENTY) begin
            decCorrect = {1'b1, 4'(raw - NAB_DEC_TEN)};
         end else begin
            decCorrect = bad;
         end
      end else if (!raw[4]) begin
         decCorrect = (raw < NAB_DEC_TEN) ? raw : bad;
      end else if (raw[3:0] >= NAB_DEC_NEG_LOW) begin
         // -10..-1 folds onto 0..9 with borrow
         decCorrect = {1'b1, 4'(raw[3:0] - NAB_DEC_NEG_LOW)};
      end else begin
         decCorrect = bad;
      end
   endfunction

   function automatic logic regHit(input logic [AXI_AW-1:0] addr, input logic [7:0] off);
      regHit = (addr[7:2] == off[7:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // datapath

   logic [3:0] statusWord;
   logic [6:0] indexReg;
   logic [4:0] lastResult;
   logic isArith;
   logic isSub;
   logic carryIn;
   logic [3:0] logicRes;
   logic [4:0] rawSum;
   logic [4:0] arithOut;
   logic [3:0] result;
   logic doStore;
   logic [6:0] effAddr;
   logic destIsStatus;

   assign carryFlag = statusWord[NAB_SW_CARRY];
   assign resultNullFlag = statusWord[NAB_SW_NULL];
   assign compareModeFlag = statusWord[NAB_SW_COMPARE];
   assign indexEnableFlag = statusWord[NAB_SW_INDEX_EN];

   always_comb begin
      isArith = 1'b1;
      isSub = 1'b0;
      carryIn = 1'b0;
      logicRes = 4'h0;
      case (opCode)
         NAB_OP_SUM: begin
            isSub = 1'b0;
         end
         NAB_OP_SUM_CARRY: begin
            carryIn = carryFlag;
         end
         NAB_OP_DIFF: begin
            isSub = 1'b1;
         end
         NAB_OP_DIFF_BORROW: begin
            isSub = 1'b1;
            carryIn = carryFlag;
         end
         NAB_OP_OR: begin
            isArith = 1'b0;
            logicRes = firstData | secondData;
         end
         NAB_OP_AND: begin
            isArith = 1'b0;
            logicRes = firstData & secondData;
         end
         default: begin
            isArith = 1'b0;
            logicRes = firstData ^ secondData;
         end
      endcase
   end

   // 5-bit results: bit 4 is the carry or the borrow
   assign rawSum = isSub ? 5'({1'b0, firstData} - {1'b0, secondData} - {4'h0, carryIn})
                         : 5'({1'b0, firstData} + {1'b0, secondData} + {4'h0, carryIn});
   assign arithOut = decimalModeFlag ? decCorrect(rawSum, isSub) : rawSum;
   assign result = isArith ? arithOut[3:0] : logicRes;

   // logic ops store regardless of compare mode
   assign doStore = !isArith || !compareModeFlag;

   // index applies to memory destinations only, general register addresses are direct
   assign effAddr = (opImmForm && indexEnableFlag) ? 7'(firstAddr + indexReg) : firstAddr;
   assign destIsStatus = opImmForm && (effAddr == NAB_STATUS_ADDR);

   // write-back towards the first operand location
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wrValid <= 1'b0;
         wrToRegister <= 1'b0;
         wrAddr <= 7'h00;
         wrData <= 4'h0;
      end else begin
         wrValid <= opValid && doStore && !destIsStatus;
         if (opValid) begin
            wrToRegister <= !opImmForm;
            wrAddr <= effAddr;
            wrData <= result;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic awHeld;
   logic wHeld;
   logic [AXI_AW-1:0] awAddrQ;
   logic [7:0] wDataQ;
   logic wStrbQ;
   logic doWrite;
   logic swStatus;
   logic swMode;
   logic swIndex;

   assign s_axi_awready = !awHeld;
   assign s_axi_wready = !wHeld;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign swStatus = doWrite && wStrbQ && regHit(awAddrQ, NAB_OFF_STATUS);
   assign swMode = doWrite && wStrbQ && regHit(awAddrQ, NAB_OFF_MODE);
   assign swIndex = doWrite && wStrbQ && regHit(awAddrQ, NAB_OFF_INDEX);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         awAddrQ <= '0;
      end else if (s_axi_awvalid && !awHeld) begin
         awHeld <= 1'b1;
         awAddrQ <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wHeld <= 1'b0;
         wDataQ <= 8'h00;
         wStrbQ <= 1'b0;
      end else if (s_axi_wvalid && !wHeld) begin
         wHeld <= 1'b1;
         wDataQ <= s_axi_wdata[7:0];
         wStrbQ <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= NAB_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (regHit(awAddrQ, NAB_OFF_STATUS) || regHit(awAddrQ, NAB_OFF_MODE) ||
                         regHit(awAddrQ, NAB_OFF_INDEX) || regHit(awAddrQ, NAB_OFF_RESULT))
                        ? NAB_RESP_OKAY : NAB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= NAB_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= NAB_RESP_OKAY;
         if (regHit(s_axi_araddr, NAB_OFF_STATUS)) begin
            s_axi_rdata <= {28'h0, statusWord};
         end else if (regHit(s_axi_araddr, NAB_OFF_MODE)) begin
            s_axi_rdata <= {31'h0, decimalModeFlag};
         end else if (regHit(s_axi_araddr, NAB_OFF_INDEX)) begin
            s_axi_rdata <= {25'h0, indexReg};
         end else if (regHit(s_axi_araddr, NAB_OFF_RESULT)) begin
            s_axi_rdata <= {27'h0, lastResult};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= NAB_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and status state

   // an alu update in the same cycle as a software write wins, and the software write is dropped whole
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         statusWord <= NAB_RST_STATUS;
      end else if (opValid && doStore && destIsStatus) begin
         statusWord <= result;
      end else if (opValid && isArith) begin
         statusWord[NAB_SW_CARRY] <= arithOut[4];
         if (!compareModeFlag) begin
            statusWord[NAB_SW_NULL] <= (arithOut[3:0] == 4'h0);
         end else if (arithOut[3:0] != 4'h0) begin
            statusWord[NAB_SW_NULL] <= 1'b0;
         end
      end else if (swStatus) begin
         statusWord <= wDataQ[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         decimalModeFlag <= NAB_RST_DECIMAL;
         indexReg <= NAB_RST_INDEX;
      end else begin
         if (swMode) begin
            decimalModeFlag <= wDataQ[NAB_MODE_DECIMAL];
         end
         if (swIndex) begin
            indexReg <= wDataQ[6:0];
         end
      end
   end

   // last result for readback: digit plus carry, arithmetic or logic
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lastResult <= NAB_RST_RESULT;
      end else if (opValid) begin
         lastResult <= {isArith & arithOut[4], result};
      end
   end
endmodule

/* File: testbench/nab_alu_sva.sv */
// concurrent checks on the nibble alu sequencer ports
`timescale 1ns/1ps
module nab_alu_chk (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic opValid,
   input wire nab_pkg::nab_op_t opCode,
   input wire logic opImmForm,
   input wire logic [6:0] firstAddr,
   input wire logic [3:0] firstData,
   input wire logic [3:0] secondData,
   input wire logic wrValid,
   input wire logic wrToRegister,
   input wire logic [6:0] wrAddr,
   input wire logic [3:0] wrData,
   input wire logic carryFlag,
   input wire logic resultNullFlag,
   input wire logic compareModeFlag,
   input wire logic decimalModeFlag,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid
);
   import nab_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire logic [4:0] sumAb = 5'(firstData) + 5'(secondData);
   wire logic [4:0] difAb = 5'(firstData) - 5'(secondData);
   wire logic [4:0] sumC = sumAb + 5'(carryFlag);
   // binary register-form arithmetic that must store
   wire logic binR = opValid && !decimalModeFlag && !compareModeFlag && !opImmForm;
   wire logic cmpDif = opValid && opCode == NAB_OP_DIFF && compareModeFlag;
   property p_bin_sum;
      binR && opCode == NAB_OP_SUM |=> wrValid && wrData == $past(sumAb[3:0])
         && carryFlag == $past(sumAb[4]);
   endproperty
   a_bin_sum: assert property (p_bin_sum) else $error("binary sum wrong");
   property p_null_dif;
      binR && opCode == NAB_OP_DIFF |=> resultNullFlag == ($past(difAb[3:0]) == 4'h0);
   endproperty
   a_null_dif: assert property (p_null_dif) else $error("null flag wrong");
   property p_no_store;
      opValid && opCode <= NAB_OP_DIFF_BORROW && compareModeFlag |=> !wrValid;
   endproperty
   a_no_store: assert property (p_no_store) else $error("compare stored");
   // a decimal difference of -10 folds onto a zero digit, so it keeps the null flag too
   property p_cmp_null;
      cmpDif |=> resultNullFlag == ($past(firstData == secondData ||
         (decimalModeFlag && difAb == 5'h16)) && $past(resultNullFlag));
   endproperty
   a_cmp_null: assert property (p_cmp_null) else $error("compare null wrong");
   property p_cmp_carry;
      cmpDif && firstData <= 4'h9 && secondData <= 4'h9 |=>
         carryFlag == $past(firstData < secondData);
   endproperty
   a_cmp_carry: assert property (p_cmp_carry) else $error("compare carry wrong");
   property p_dec_carry;
      opValid && opCode == NAB_OP_SUM && decimalModeFlag && !compareModeFlag && !opImmForm
         && sumAb <= 5'h13 |=> carryFlag == $past(sumAb > 5'h09);
   endproperty
   a_dec_carry: assert property (p_dec_carry) else $error("decimal carry wrong");
   property p_logic_keep;
      opValid && opCode >= NAB_OP_OR && !opImmForm && !s_axi_awvalid && !s_axi_wvalid
         |=> $stable(carryFlag) && $stable(resultNullFlag);
   endproperty
   a_logic_keep: assert property (p_logic_keep) else $error("logic op moved flags");
   property p_dest;
      opValid && !opImmForm && (opCode >= NAB_OP_OR || !compareModeFlag) |=>
         wrValid && wrToRegister && wrAddr == $past(firstAddr);
   endproperty
   a_dest: assert property (p_dest) else $error("store target wrong");
   property p_carry_in;
      binR && opCode == NAB_OP_SUM_CARRY |=> wrData == $past(sumC[3:0]);
   endproperty
   a_carry_in: assert property (p_carry_in) else $error("carry in ignored");
   cover property (cmpDif ##1 resultNullFlag);
   cover property (wrValid && decimalModeFlag);
   cover property (opValid && opImmForm && firstAddr == NAB_STATUS_ADDR);
endmodule

bind nab_alu nab_alu_chk i_nab_alu_chk (.*);

/* File: testbench/nab_seq_model.sv */
// sequencer model presenting one alu operation per call
`timescale 1ns/1ps
module nab_seq_model (
   input wire logic sys_clk,
   output logic opValid,
   output nab_pkg::nab_op_t opCode,
   output logic opImmForm,
   output logic [6:0] firstAddr,
   output logic [3:0] firstData,
   output logic [3:0] secondData
);
   import nab_pkg::*;
   initial begin
      opValid = 1'h0;
      opCode = NAB_OP_SUM;
      opImmForm = 1'h0;
      firstAddr = 7'h00;
      firstData = 4'h0;
      secondData = 4'h0;
   end
   // callers keep decimal operands in range unless testing misuse
   // chained compares come digit by digit, low digit first
   task automatic issue(input nab_op_t o, input logic i, input logic [6:0] ad,
      input logic [3:0] a, input logic [3:0] b);
      @(posedge sys_clk);
      opValid <= 1'h1;
      opCode <= o;
      opImmForm <= i;
      firstAddr <= ad;
      firstData <= a;
      secondData <= b;
      @(posedge sys_clk);
      // operands are stale once taken, so show garbage
      opValid <= 1'h0;
      firstData <= ~a;
      secondData <= ~b;
      #1;
   endtask
endmodule

/* File: testbench/test_nab_alu.sv */
// self-checking bench for the nibble alu
`timescale 1ns/1ps
module test_nab_alu;
   import nab_pkg::*;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic opValid, opImmForm, wrValid, wrToRegister, carryFlag, resultNullFlag;
   logic compareModeFlag, decimalModeFlag, indexEnableFlag;
   nab_op_t opCode;
   logic [6:0] firstAddr, wrAddr;
   logic [3:0] firstData, secondData, wrData;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int nFail = 0;
   int testsRun = 0;
   int cyc = 0;
   always #2.5 sys_clk = ~sys_clk;
   nab_alu i_nab_alu (.*);
   nab_seq_model i_nab_seq_model (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [35:0] s, input logic [35:0] e);
      testsRun++;
      if (s !== e) begin
         nFail++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      if (nFail == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk(36'(s_axi_bresp), 36'(r));
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk({s_axi_rresp, s_axi_rdata}, {r, d});
   endtask
   // e holds store, null, carry and the digit (digit only looked at on a store)
   task automatic op(input nab_op_t o, input logic i, input logic [6:0] ad,
      input logic [7:0] ab, input logic [6:0] e);
      i_nab_seq_model.issue(o, i, ad, ab[7:4], ab[3:0]);
      chk(36'({wrValid, resultNullFlag, carryFlag, e[6] ? wrData : e[3:0]}), 36'(e));
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         nFail++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'h0;
      for (int k = 0; k < 4; k++) axr(8'(4 * k), 32'h0, NAB_RESP_OKAY);
      axr(8'h10, 32'h0, NAB_RESP_SLVERR);
      axw(8'h20, 32'h1, NAB_RESP_SLVERR);
      op(NAB_OP_SUM, 1'h0, 7'h02, 8'h93, 7'h4c);
      op(NAB_OP_SUM, 1'h0, 7'h02, 8'hf1, 7'h70);
      op(NAB_OP_DIFF, 1'h0, 7'h02, 8'h35, 7'h5e);
      op(NAB_OP_SUM_CARRY, 1'h0, 7'h02, 8'h23, 7'h46);
      op(NAB_OP_DIFF, 1'h1, 7'h03, 8'h01, 7'h5f);
      op(NAB_OP_DIFF_BORROW, 1'h1, 7'h03, 8'h54, 7'h60);
      axw(NAB_OFF_MODE, 32'h1, NAB_RESP_OKAY);
      chk(36'(decimalModeFlag), 36'h1);
      op(NAB_OP_SUM, 1'h0, 7'h02, 8'h95, 7'h54);
      op(NAB_OP_DIFF, 1'h0, 7'h02, 8'h35, 7'h58);
      op(NAB_OP_DIFF, 1'h0, 7'h02, 8'h77, 7'h60);
      op(NAB_OP_SUM, 1'h0, 7'h02, 8'hff, 7'h5c);
      axw(NAB_OFF_STATUS, 32'h6, NAB_RESP_OKAY);
      chk(36'(compareModeFlag), 36'h1);
      op(NAB_OP_DIFF, 1'h1, 7'h01, 8'h0a, 7'h30);
      op(NAB_OP_DIFF, 1'h1, 7'h01, 8'h11, 7'h20);
      op(NAB_OP_DIFF_BORROW, 1'h1, 7'h02, 8'h22, 7'h20);
      op(NAB_OP_DIFF_BORROW, 1'h1, 7'h03, 8'h33, 7'h20);
      axw(NAB_OFF_STATUS, 32'h6, NAB_RESP_OKAY);
      op(NAB_OP_DIFF, 1'h0, 7'h01, 8'h12, 7'h10);
      op(NAB_OP_DIFF_BORROW, 1'h0, 7'h02, 8'h22, 7'h10);
      op(NAB_OP_OR, 1'h0, 7'h04, 8'h5a, 7'h5f);
      op(NAB_OP_AND, 1'h0, 7'h04, 8'hca, 7'h58);
      op(NAB_OP_XOR, 1'h0, 7'h04, 8'hca, 7'h56);
      axr(NAB_OFF_STATUS, 32'h5, NAB_RESP_OKAY);
      axw(NAB_OFF_MODE, 32'h0, NAB_RESP_OKAY);
      axw(NAB_OFF_STATUS, 32'h0, NAB_RESP_OKAY);
      op(NAB_OP_SUM, 1'h1, NAB_STATUS_ADDR, 8'h05, 7'h10);
      axr(NAB_OFF_STATUS, 32'h5, NAB_RESP_OKAY);
      op(NAB_OP_DIFF, 1'h1, NAB_STATUS_ADDR, 8'h55, 7'h00);
      axr(NAB_OFF_STATUS, 32'h4, NAB_RESP_OKAY);
      axw(NAB_OFF_INDEX, 32'h5, NAB_RESP_OKAY);
      axw(NAB_OFF_STATUS, 32'h8, NAB_RESP_OKAY);
      chk(36'(indexEnableFlag), 36'h1);
      op(NAB_OP_OR, 1'h1, 7'h10, 8'h12, 7'h43);
      chk(36'({wrToRegister, wrAddr}), 36'h15);
      axw(NAB_OFF_RESULT, 32'h1f, NAB_RESP_OKAY);
      axr(NAB_OFF_RESULT, 32'h3, NAB_RESP_OKAY);
      // a write with its low byte lane disabled is answered but must leave the index alone
      s_axi_wstrb <= 4'h0;
      axw(NAB_OFF_INDEX, 32'h7f, NAB_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axr(NAB_OFF_INDEX, 32'h5, NAB_RESP_OKAY);
      finish_test();
   end
endmodule
